// ===== verilog/mccd_core.sv
// design: executor for clear, complement, decrement, call and dog-kick opcodes behind an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite slave port and the address map.

// ------------------------------------------------------------------
// executor top
// ------------------------------------------------------------------
// Notes on behaviour
// - clear accumulator: zero it, set zero flag
// - call pushes program counter plus one
// - call target: literal, page bits, bit eight clear
// - call takes two cycles, flags unchanged
// - kick clears the dog counter
// - kick clears prescaler only when dog-assigned
// - kick sets expiry and sleep bits
// - clear register: zero location, set zero flag
// - invert register, zero flag from result
// - destination bit: zero accumulator, one register
// - decrement register, zero flag from result
// - decrement-skip stores result, flags unchanged
// - zero result skips: extra no-operation cycle
module mccd_core
   import mccd_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   mccd_state_e          state;               // executor sequence
   logic [1:0]           div;                 // clock divider for instruction cycles
   logic                 cyc_en;              // one-cycle instruction-cycle enable
   logic [11:0]          opcode;              // opcode being executed
   logic [7:0]           acc;                 // accumulator
   logic [7:0]           status;              // status byte
   logic [PROG_W-1:0]    program_counter;     // program counter
   logic [PROG_W-1:0]    stack [2];           // two-level return stack, entry 0 on top
   logic [7:0]           dog_counter;         // dog counter value
   logic [7:0]           prescaler;           // shared prescaler value
   logic                 pre_to_dog;          // prescaler assignment
   logic [7:0]           rf [RF_DEPTH];       // register file
   mccd_acc_s            ap;                  // captured address phase
   logic                 rd_wait;             // read data phase, first cycle

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   logic                 ap_take;             // address phase taken this edge
   logic                 bus_wr;              // data-phase write lands this edge
   logic                 idle;                // working registers open to software
   logic [4:0]           widx;                // register-file index of the write

   assign ap_take   = HSEL && HREADY && (HTRANS == HTRANS_NSEQ);
   assign idle      = (state == ST_IDLE);
   // working registers only accept software writes between instructions,
   // so an opcode never races a bus write on the same bit
   assign bus_wr    = ap.write && idle;
   assign widx      = ap.offs[6:2];
   assign HREADYOUT = !rd_wait;               // reads take one wait state
   assign HRESP     = 1'b0;                   // always OKAY

   // capture the address phase; only whole-word transfers are expected
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ap <= '0;
      end else if (HREADYOUT) begin
         ap.write <= ap_take && HWRITE;
         ap.read  <= ap_take && !HWRITE;
         ap.offs  <= HADDR[7:0];
      end
   end

   // the wait state lets a preceding write land before the read is sampled
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rd_wait <= 1'b0;
      end else begin
         rd_wait <= HREADYOUT && ap_take && !HWRITE;
      end
   end

   // ----------------------------------------------------------------
   // read mux and read data flop
   // ----------------------------------------------------------------
   logic [31:0] rd_val;                       // value of the addressed word

   always_comb begin
      rd_val = 32'h0000_0000;                 // unmapped offsets read as zero
      if (ap.offs[7] == RF_WINDOW) begin
         rd_val[7:0] = rf[widx];
      end else begin
         case (ap.offs)
            A_INSTR:  rd_val[11:0] = opcode;
            A_ACC:    rd_val[7:0] = acc;
            A_STATUS: rd_val[7:0] = status;
            A_PROG:   rd_val[PROG_W-1:0] = program_counter;
            A_STACK: begin
               rd_val[PROG_W-1:0]              = stack[0];
               rd_val[STK_HI_LSB+PROG_W-1:STK_HI_LSB] = stack[1];
            end
            A_DOG: begin
               rd_val[7:0]               = dog_counter;
               rd_val[PRE_LSB+7:PRE_LSB] = prescaler;
               rd_val[ASSIGN_BIT]        = pre_to_dog;
            end
            A_STATE:  rd_val[1:0] = state;
            default:  rd_val = 32'h0000_0000;
         endcase
      end
   end

   // data output comes from a flop, loaded in the wait cycle
   always_ff @(posedge MCLK) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_wait) begin
         HRDATA <= rd_val;
      end
   end

   // ----------------------------------------------------------------
   // instruction-cycle divider
   // ----------------------------------------------------------------
   // free running, so an opcode's first instruction cycle spans one to four clocks, later ones four
   always_ff @(posedge MCLK) begin
      if (RST) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
      end
   end
   assign cyc_en = (div == DIV_LAST);

   // ----------------------------------------------------------------
   // decode and datapath
   // ----------------------------------------------------------------
   logic       is_clracc, is_kick, is_clrreg, is_invert, is_decr, is_dskip, is_call;
   logic       exe;                           // opcode takes effect this edge
   logic [4:0] fsel;                          // addressed register
   logic       dest;                          // destination select
   logic [7:0] src;                           // addressed register content
   logic [7:0] res;                           // result byte
   logic       wr_acc, wr_rf, upd_zero;       // result steering
   logic       skip;                          // decrement-skip hit zero

   assign is_clracc = (opcode == OP_CLRACC);
   assign is_kick   = (opcode == OP_KICK);
   assign is_clrreg = ((opcode & M_CLRREG) == V_CLRREG);
   assign is_invert = ((opcode & M_FD) == V_INVERT);
   assign is_decr   = ((opcode & M_FD) == V_DECR);
   assign is_dskip  = ((opcode & M_FD) == V_DSKIP);
   assign is_call   = ((opcode & M_CALL) == V_CALL);
   assign exe       = (state == ST_RUN) && cyc_en;
   assign fsel      = opcode[4:0];
   assign dest      = opcode[DEST_BIT];
   assign src       = rf[fsel];

   // result and its destination; unknown opcodes act as no-operation
   always_comb begin
      res      = 8'h00;
      wr_acc   = 1'b0;
      wr_rf    = 1'b0;
      upd_zero = 1'b0;
      if (is_clracc) begin
         wr_acc   = 1'b1;
         upd_zero = 1'b1;
      end else if (is_clrreg) begin
         wr_rf    = 1'b1;
         upd_zero = 1'b1;
      end else if (is_invert) begin
         res      = ~src;
         wr_acc   = !dest;
         wr_rf    = dest;
         upd_zero = 1'b1;
      end else if (is_decr || is_dskip) begin
         res      = src - 8'h01;
         wr_acc   = !dest;
         wr_rf    = dest;
         upd_zero = is_decr;                  // decrement-skip leaves flags alone
      end
   end
   assign skip = is_dskip && (res == 8'h00);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // call and a taken skip spend a second instruction cycle as no-operation
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (bus_wr && ap.offs == A_INSTR) begin
               state <= ST_RUN;
            end
            ST_RUN: if (cyc_en) begin
               state <= (is_call || skip) ? ST_TAIL : ST_IDLE;
            end
            ST_TAIL: if (cyc_en) begin
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // opcode latch
   always_ff @(posedge MCLK) begin
      if (RST) begin
         opcode <= 12'h000;
      end else if (bus_wr && ap.offs == A_INSTR) begin
         opcode <= HWDATA[11:0];
      end
   end

   // ----------------------------------------------------------------
   // accumulator and status
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         acc <= 8'h00;
      end else if (exe && wr_acc) begin
         acc <= res;
      end else if (bus_wr && ap.offs == A_ACC) begin
         acc <= HWDATA[7:0];
      end
   end

   // only the zero flag and the two active-low bits are touched by opcodes
   always_ff @(posedge MCLK) begin
      if (RST) begin
         status <= STATUS_RST;
      end else if (exe && upd_zero) begin
         status[ZERO_BIT] <= (res == 8'h00);
      end else if (exe && is_kick) begin
         status[EXPIRY_BIT] <= 1'b1;
         status[SLEEP_BIT]  <= 1'b1;
      end else if (bus_wr && ap.offs == A_STATUS) begin
         status <= HWDATA[7:0];
      end
   end

   // ----------------------------------------------------------------
   // program counter and return stack
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         program_counter <= '0;
      end else if (exe && is_call) begin
         program_counter <= {status[PAGE_HI:PAGE_LO], 1'b0, opcode[7:0]};
      end else if (exe) begin
         // a taken skip steps over the discarded instruction as well
         program_counter <= program_counter + (skip ? PROG_W'(2) : PROG_W'(1));
      end else if (bus_wr && ap.offs == A_PROG) begin
         program_counter <= HWDATA[PROG_W-1:0];
      end
   end

   // push only; a third nested call drops the oldest entry
   always_ff @(posedge MCLK) begin
      if (RST) begin
         stack[0] <= '0;
         stack[1] <= '0;
      end else if (exe && is_call) begin
         stack[0] <= program_counter + PROG_W'(1);
         stack[1] <= stack[0];
      end
   end

   // ----------------------------------------------------------------
   // dog counter and prescaler
   // ----------------------------------------------------------------
   // counting itself lives elsewhere; software may preset both fields
   always_ff @(posedge MCLK) begin
      if (RST) begin
         dog_counter <= 8'h00;
         prescaler   <= 8'h00;
         pre_to_dog  <= 1'b0;
      end else if (exe && is_kick) begin
         dog_counter <= 8'h00;
         if (pre_to_dog) begin
            prescaler <= 8'h00;
         end
      end else if (bus_wr && ap.offs == A_DOG) begin
         dog_counter <= HWDATA[7:0];
         prescaler   <= HWDATA[PRE_LSB+7:PRE_LSB];
         pre_to_dog  <= HWDATA[ASSIGN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   for (genvar i = 0; i < RF_DEPTH; i++) begin : g_rf
      always_ff @(posedge MCLK) begin
         if (RST) begin
            rf[i] <= 8'h00;
         end else if (exe && wr_rf && fsel == 5'(i)) begin
            rf[i] <= res;
         end else if (bus_wr && ap.offs[7] == RF_WINDOW && widx == 5'(i)) begin
            rf[i] <= HWDATA[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   clracc_zero_a: assert property (exe && is_clracc |=> acc == 8'h00 && status[ZERO_BIT]
      && status[7:3] == $past(status[7:3]) && status[1:0] == $past(status[1:0]))
      else $error("clear accumulator result wrong");
   call_push_a: assert property (exe && is_call |=> stack[0] == $past(program_counter) + PROG_W'(1))
      else $error("call pushed wrong return address");
   call_target_a: assert property (exe && is_call |=>
      program_counter == {$past(status[PAGE_HI:PAGE_LO]), 1'b0, $past(opcode[7:0])})
      else $error("call target wrong");
   call_two_a: assert property (exe && is_call |=> state == ST_TAIL && status == $past(status)
      ##4 state == ST_IDLE)
      else $error("call not two cycles or flags moved");
   dog_clear_a: assert property (exe && is_kick |=> dog_counter == 8'h00)
      else $error("dog counter not cleared");
   pre_keep_a: assert property (exe && is_kick |=>
      prescaler == ($past(pre_to_dog) ? 8'h00 : $past(prescaler)))
      else $error("prescaler handled wrong on kick");
   kick_bits_a: assert property (exe && is_kick |=> status[EXPIRY_BIT] && status[SLEEP_BIT])
      else $error("active-low status bits not set");
   clrreg_zero_a: assert property (exe && is_clrreg |=> rf[$past(fsel)] == 8'h00 && status[ZERO_BIT])
      else $error("clear register result wrong");
   invert_dest_a: assert property (exe && is_invert |=>
      ($past(dest) ? rf[$past(fsel)] : acc) == ~$past(src))
      else $error("invert result or destination wrong");
   decr_zero_a: assert property (exe && is_decr |=>
      ($past(dest) ? rf[$past(fsel)] : acc) == $past(src) - 8'h01
      && status[ZERO_BIT] == ($past(src) == 8'h01))
      else $error("decrement result or zero flag wrong");
   dskip_flags_a: assert property (exe && is_dskip |=> status == $past(status))
      else $error("decrement-skip changed flags");
   dskip_cycles_a: assert property (exe && is_dskip |=>
      state == (($past(src) == 8'h01) ? ST_TAIL : ST_IDLE))
      else $error("decrement-skip cycle count wrong");

   call_seen_c:  cover property (exe && is_call);
   skip_seen_c:  cover property (exe && skip);
   kick_pre_c:   cover property (exe && is_kick && pre_to_dog);
   read_wait_c:  cover property (rd_wait ##2 ap_take);

endmodule : mccd_core

// ===== inc/mccd_pkg.sv
// package: register map, opcode encodings, field layout and types of the instruction executor
package mccd_pkg;

   // ----------------------------------------------------------------
   // register map (byte offsets, decoded on the low address byte)
   // ----------------------------------------------------------------
   localparam logic [7:0]  A_INSTR     = 8'h00;   // opcode, write starts execution
   localparam logic [7:0]  A_ACC       = 8'h04;   // accumulator
   localparam logic [7:0]  A_STATUS    = 8'h08;   // status byte
   localparam logic [7:0]  A_PROG      = 8'h0C;   // program counter
   localparam logic [7:0]  A_STACK     = 8'h10;   // return stack, read only
   localparam logic [7:0]  A_DOG       = 8'h14;   // dog counter, prescaler, assignment
   localparam logic [7:0]  A_STATE     = 8'h18;   // executor state, read only
   localparam logic [7:0]  A_RF_BASE   = 8'h80;   // 32 register-file words from here
   localparam logic [0:0]  RF_WINDOW   = 1'h1;    // address bit 7 selects the register file

   // ----------------------------------------------------------------
   // opcode encodings (12-bit instruction word)
   // ----------------------------------------------------------------
   localparam logic [11:0] OP_CLRACC   = 12'h040; // clear_accumulator_op
   localparam logic [11:0] OP_KICK     = 12'h004; // kick_dog_op
   localparam logic [11:0] M_CLRREG    = 12'hFE0; // clear_reg_op mask / value
   localparam logic [11:0] V_CLRREG    = 12'h060;
   localparam logic [11:0] M_FD        = 12'hFC0; // mask for ops with f and d fields
   localparam logic [11:0] V_INVERT    = 12'h240; // invert_reg_op
   localparam logic [11:0] V_DECR      = 12'h0C0; // decrement_reg_op
   localparam logic [11:0] V_DSKIP     = 12'h2C0; // decrement_skip_null_op
   localparam logic [11:0] M_CALL      = 12'hF00; // subroutine call
   localparam logic [11:0] V_CALL      = 12'h900;
   localparam int          DEST_BIT    = 5;       // destination select inside opcode

   // ----------------------------------------------------------------
   // status byte and dog word layout, reset values
   // ----------------------------------------------------------------
   localparam int          ZERO_BIT    = 2;       // result-zero flag
   localparam int          SLEEP_BIT   = 3;       // sleep_status_bit, active low
   localparam int          EXPIRY_BIT  = 4;       // expiry_status_bit, active low
   localparam int          PAGE_LO     = 5;       // page select bits feed call target
   localparam int          PAGE_HI     = 6;
   localparam logic [7:0]  STATUS_RST  = 8'h18;   // both active-low bits idle high
   localparam int          PRE_LSB     = 8;       // prescaler field in dog word
   localparam int          ASSIGN_BIT  = 16;      // 1: prescaler belongs to the dog counter
   localparam int          STK_HI_LSB  = 16;      // second stack level in stack word

   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int          PROG_W      = 11;      // program counter width
   localparam int          RF_DEPTH    = 32;      // register-file locations
   localparam logic [1:0]  DIV_LAST    = 2'h3;    // four clocks per instruction cycle
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,                            // waiting for an opcode
      ST_RUN  = 2'b01,                            // first instruction cycle
      ST_TAIL = 2'b11                             // forced no-operation cycle
   } mccd_state_e;

   typedef struct packed {
      logic       write;                          // captured write strobe
      logic       read;                           // captured read strobe
      logic [7:0] offs;                           // captured low address byte
   } mccd_acc_s;

endpackage : mccd_pkg

// ===== dv/test_mccd_core.sv
// testbench: opcode stream cycling through all seven kinds with random operands on the executor, checked against an integer model
module test_mccd_core
   import mccd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // bus signals, model state, counters
   // ----------------------------------------------------------------
   logic        MCLK   = 1'b0;
   logic        RST    = 1'b1;       // synchronous, held two edges
   logic [31:0] HADDR  = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic        HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic        HREADYOUT;
   logic        HRESP;
   logic [31:0] seed   = 32'h18;     // xorshift state, starts at 24
   logic [31:0] q;                   // last read word
   logic [11:0] op;                  // opcode under test
   int          n_fail, n_compared, cyc, i, f, d, k, v, r, kind, tl;
   int          acc, st, pc, s0, s1, dog, pre, asg;
   int          rf[32];              // model register file

   mccd_core mccd_core_i (.MCLK(MCLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP));

   // free-running clock, 50 ns period
   always #25 MCLK = ~MCLK;

   // hang guard: whole run needs about 6700 clocks
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one single AHB transfer; waits on hready, never on a fixed count
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
      HTRANS <= HTRANS_NSEQ;
      HADDR  <= {24'h0, a};
      HWRITE <= w;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= dat;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
      check(32'(HRESP), 32'h0);
   endtask : xfer

   task cmp(input logic [7:0] a, input int e);
      xfer(1'b0, a, 32'h0);
      check(q, 32'(e));
   endtask : cmp

   // opcode, then a back-to-back acc write that must be dropped while busy;
   // a one-cycle opcode may finish before that write lands, depending on the
   // divider phase, so the write is only tried where a forced no-operation
   // cycle keeps the executor busy for certain
   task run();
      int saw;
      saw = 0;
      xfer(1'b1, A_INSTR, {20'h0, op});
      if (tl == 1) begin
         xfer(1'b1, A_ACC, 32'(acc ^ 255));
      end
      repeat (20) begin
         xfer(1'b0, A_STATE, 32'h0);
         if (q === 32'h3) saw = 1;
         if (q === 32'h0) break;
      end
      check(32'(saw), 32'(tl));
   endtask : run

   task compare_all();
      cmp(A_ACC, acc);
      cmp(A_STATUS, st);
      cmp(A_PROG, pc);
      cmp(A_STACK, (s1 << 16) | s0);
      cmp(A_DOG, (asg << 16) | (pre << 8) | dog);
      cmp(8'(A_RF_BASE + 4 * f), rf[f]);
   endtask : compare_all

   task end_sim();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      acc = 0; st = 'h18; pc = 0; s0 = 0; s1 = 0; dog = 0; pre = 0; asg = 0; f = 0;
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      compare_all();
      cmp(8'h1C, 0);                             // unmapped read gives zero
      for (i = 0; i < 210; i++) begin
         kind = i % 7;
         f = int'(rnd() & 31);
         d = int'(rnd() & 1);
         k = int'(rnd() & 255);
         // boundary values favoured: 1 decrements to zero, 0 wraps, FF inverts to zero
         case (rnd() & 7)
            0: v = 1;
            1: v = 0;
            2: v = 255;
            default: v = int'(rnd() & 255);
         endcase
         rf[f] = v;
         xfer(1'b1, 8'(A_RF_BASE + 4 * f), 32'(v));
         st = int'(rnd() & 255);
         xfer(1'b1, A_STATUS, 32'(st));
         r = int'(rnd() & 32'h1FFFF);
         dog = r & 255;
         pre = (r >> 8) & 255;
         asg = r >> 16;
         xfer(1'b1, A_DOG, 32'(r));
         tl = 0;
         case (kind)
            0: begin
               op = OP_CLRACC; acc = 0; st = st | 4;
            end
            1: begin
               op = OP_KICK; dog = 0; st = st | 'h18;
               if (asg == 1) pre = 0;
            end
            2: begin
               op = V_CLRREG | 12'(f); rf[f] = 0; st = st | 4;
            end
            3, 4, 5: begin
               op = (kind == 3 ? V_INVERT : kind == 4 ? V_DECR : V_DSKIP) | 12'((d << DEST_BIT) | f);
               r = kind == 3 ? (~v & 255) : ((v - 1) & 255);
               if (d == 1) rf[f] = r;
               else acc = r;
               if (kind != 5) st = (r == 0) ? (st | 4) : (st & ~4);
               tl = (kind == 5 && r == 0) ? 1 : 0;
            end
            default: begin
               op = V_CALL | 12'(k); s1 = s0; s0 = (pc + 1) & 'h7FF; tl = 1;
            end
         endcase
         if (kind == 6) pc = (((st >> PAGE_LO) & 3) << 9) | k;
         else pc = (pc + 1 + tl) & 'h7FF;
         run();
         compare_all();
      end
      end_sim();
   end

endmodule : test_mccd_core
